// ===== cbt_balance_timer.sv
// Cell balance gate outputs with shared on-time counter and
// power-down handling, reached as an AHB-Lite slave.
// Assumes one 100 MHz clock; the power-down pin is asynchronous.
//
// Function
// - Six independent balance gate outputs, each off or driven high.
// - Each gate follows its balance-select bit; select clears to zero.
// - Zero shutdown delay: pin falling edge turns gates off, powers down.
// - Nonzero shutdown delay: gates stay until the delay elapses.
// - Shutdown timer and on-time counter run independently.
// - Six on-time registers, 0 to 37.2 min in 72 s steps.
// - Zero on-time leaves the output untimed, on until cleared.
// - Writing on-time only arms; select write starts output and timer.
// - On expiry gate goes low, select bit clears, on-time kept.
// - All on-time registers reset to zero.
// - One shared counter, started by nonzero select write with timing.
// - Counter compared with on-times every 4.5 s tick.
// - Counter reaching an on-time turns that output off.
// - Select writes override timers; clearing turns output off at once.
// - A write to an active on-time register restarts the counter only if it is running.
// - Zero written to an active on-time also turns that output off.
// - Writes to an inactive on-time register leave the counter alone.
// - When all timed outputs expire the counter returns to zero.
// - Outputs enabled mid-count are timed against the running count.
// - Select bit 2 drives the first output, upward from there.
// - On-time count LSB sits at bit 3.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cbt_balance_timer #(
  parameter int unsigned TICK_CYCLES = cbt_pkg::TICK_CYCLES,
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic power_down_n_pin,
  output logic [cbt_pkg::NCH-1:0] balance_gate_out,
  output logic powered_down
);

  localparam int unsigned NCH = cbt_pkg::NCH;
  localparam int unsigned ONT_W = cbt_pkg::ONT_W;
  localparam int unsigned SUB_W = cbt_pkg::SUB_W;
  localparam logic [NCH-1:0] SEL_ZERO = cbt_pkg::SEL_RST;

  // Address decode, shared by read and write paths
  function automatic logic [3:0] regIdx(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    if (b == cbt_pkg::OFF_SEL) regIdx = cbt_pkg::IDX_SEL;
    else if (b >= cbt_pkg::OFF_ONT1 && b <= cbt_pkg::OFF_ONT6 &&
             b[1:0] == 2'h0)
      regIdx = 4'(cbt_pkg::IDX_ONT1 + 4'((b - cbt_pkg::OFF_ONT1) >> 2));
    else if (b == cbt_pkg::OFF_PDT) regIdx = cbt_pkg::IDX_PDT;
    else if (b == cbt_pkg::OFF_STAT) regIdx = cbt_pkg::IDX_STAT;
    else regIdx = cbt_pkg::IDX_NONE;
  endfunction

  // Bus state
  logic wrPend_r;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [31:0] rdData_r;

  // Block state
  logic [NCH-1:0] balSel_r, selNxt;
  logic [ONT_W-1:0] onTime_r [NCH];
  logic [ONT_W-1:0] pdtVal_r;
  logic cntRun_r, cntRunNxt;
  logic [ONT_W-1:0] cntStep_r, cntStepNxt;
  logic [SUB_W-1:0] cntSub_r, cntSubNxt;
  logic pdRun_r, pdRunNxt;
  logic [ONT_W-1:0] pdStep_r, pdStepNxt;
  logic [SUB_W-1:0] pdSub_r, pdSubNxt;
  logic [31:0] preCnt_r;
  logic pinS1_r, pinS2_r, pinPrev_r;
  cbt_pkg::cbt_pwr_t pwr_r, pwrNxt;

  // Bus decode
  wire addrPhase = hsel && hready && htrans == cbt_pkg::HTRANS_NONSEQ;
  wire [3:0] wrIdx = regIdx(wrAddr_r);
  wire [3:0] rdIdx = regIdx(haddr);
  wire wrSel = wrPend_r && wrIdx == cbt_pkg::IDX_SEL;
  wire wrPdt = wrPend_r && wrIdx == cbt_pkg::IDX_PDT;
  wire [NCH-1:0] wdSel = hwdata[cbt_pkg::SEL_LSB +: NCH];
  wire [ONT_W-1:0] wdOnt = hwdata[cbt_pkg::ONT_LSB +: ONT_W];

  // Prescaler tick, shared by both timers
  wire tick = preCnt_r == 32'(TICK_CYCLES - 1);
  wire [ONT_W-1:0] cntTickStep = (cntSub_r == cbt_pkg::SUB_LAST) ?
                                 5'(cntStep_r + 1'b1) : cntStep_r;

  // Per-channel decode
  logic [NCH-1:0] wrOnt, timedVec, expHit, zeroOff;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign wrOnt[gi] = wrPend_r && wrIdx == 4'(cbt_pkg::IDX_ONT1 + gi);
      assign timedVec[gi] = onTime_r[gi] != cbt_pkg::ONT_ZERO;
      // Compare at each tick against the count it is moving to
      assign expHit[gi] = tick && cntRun_r && balSel_r[gi] &&
                          timedVec[gi] && !(|(wrOnt & balSel_r)) &&
                          cntTickStep == onTime_r[gi];
      assign zeroOff[gi] = wrOnt[gi] && balSel_r[gi] &&
                           wdOnt == cbt_pkg::ONT_ZERO;
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          onTime_r[gi] <= cbt_pkg::ONT_ZERO;
        end else if (wrOnt[gi]) begin
          onTime_r[gi] <= wdOnt;
        end
      end
    end
  endgenerate

  wire activeHit = |(wrOnt & balSel_r);
  wire pinLow = !pinS2_r;
  wire fallEdge = pinPrev_r && pinLow;
  wire isOn = pwr_r == cbt_pkg::PWR_ON;
  wire pdStart = isOn && fallEdge && pdtVal_r != cbt_pkg::ONT_ZERO;
  wire [ONT_W-1:0] pdTickStep = (pdSub_r == cbt_pkg::SUB_LAST) ?
                                5'(pdStep_r + 1'b1) : pdStep_r;
  wire pdExp = pdRun_r && tick && pdTickStep == pdtVal_r;
  wire pdZeroWr = pdRun_r && wrPdt && wdOnt == cbt_pkg::ONT_ZERO;
  wire goNow = isOn && fallEdge && pdtVal_r == cbt_pkg::ONT_ZERO;
  wire goDelay = (pdExp || pdZeroWr) && pinLow;
  wire goDown = goNow || goDelay;

  // Power state
  always_comb begin
    pwrNxt = pwr_r;
    case (pwr_r)
      cbt_pkg::PWR_ON: begin
        if (goDown) pwrNxt = cbt_pkg::PWR_OFF;
      end
      cbt_pkg::PWR_OFF: begin
        if (pinS2_r) pwrNxt = cbt_pkg::PWR_ON;
      end
      default: pwrNxt = cbt_pkg::PWR_ON;
    endcase
  end

  // Balance select next value
  always_comb begin
    selNxt = balSel_r & ~expHit & ~zeroOff;
    if (wrSel) selNxt = wdSel;
    if (goDown || pwr_r == cbt_pkg::PWR_OFF) selNxt = cbt_pkg::SEL_RST;
  end

  // Shared on-time counter
  always_comb begin
    cntRunNxt = cntRun_r;
    cntStepNxt = cntTickStep;
    cntSubNxt = 4'(cntSub_r + 1'b1);
    if (!cntRun_r) begin
      cntStepNxt = cbt_pkg::ONT_ZERO;
      cntSubNxt = '0;
      if (wrSel && |(wdSel & timedVec)) cntRunNxt = 1'b1;
    end else if (activeHit) begin
      cntStepNxt = cbt_pkg::ONT_ZERO;
      cntSubNxt = '0;
    end else if (!tick) begin
      cntStepNxt = cntStep_r;
      cntSubNxt = cntSub_r;
    end
    if (cntRun_r && !(|(selNxt & timedVec))) begin
      cntRunNxt = 1'b0;
      cntStepNxt = cbt_pkg::ONT_ZERO;
      cntSubNxt = '0;
    end
  end

  // Shutdown delay timer, separate from the on-time counter
  always_comb begin
    pdRunNxt = pdRun_r;
    pdStepNxt = pdStep_r;
    pdSubNxt = pdSub_r;
    if (pdStart && !pdRun_r) begin
      pdRunNxt = 1'b1;
      pdStepNxt = cbt_pkg::ONT_ZERO;
      pdSubNxt = '0;
    end else if (pdRun_r && wrPdt) begin
      pdRunNxt = !pdZeroWr;
      pdStepNxt = cbt_pkg::ONT_ZERO;
      pdSubNxt = '0;
    end else if (pdExp) begin
      pdRunNxt = 1'b0;
      pdStepNxt = cbt_pkg::ONT_ZERO;
      pdSubNxt = '0;
    end else if (pdRun_r && tick) begin
      pdStepNxt = pdTickStep;
      pdSubNxt = 4'(pdSub_r + 1'b1);
    end
  end

  // Read mux
  logic [31:0] rdVal;
  always_comb begin
    rdVal = '0;
    case (rdIdx)
      cbt_pkg::IDX_SEL: rdVal[cbt_pkg::SEL_LSB +: NCH] = balSel_r;
      cbt_pkg::IDX_PDT: rdVal[cbt_pkg::ONT_LSB +: ONT_W] = pdtVal_r;
      cbt_pkg::IDX_STAT: begin
        rdVal[cbt_pkg::ST_STEP_LSB +: ONT_W] = cntStep_r;
        rdVal[cbt_pkg::ST_RUN_BIT] = cntRun_r;
        rdVal[cbt_pkg::ST_PDRUN_BIT] = pdRun_r;
        rdVal[cbt_pkg::ST_DOWN_BIT] = pwr_r == cbt_pkg::PWR_OFF;
        rdVal[cbt_pkg::ST_PIN_BIT] = pinS2_r;
      end
      cbt_pkg::IDX_NONE: rdVal = '0;
      default: begin
        if (rdIdx >= cbt_pkg::IDX_ONT1 && rdIdx < cbt_pkg::IDX_PDT)
          rdVal[cbt_pkg::ONT_LSB +: ONT_W] =
            onTime_r[3'(rdIdx - cbt_pkg::IDX_ONT1)];
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      rdData_r <= '0;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      if (addrPhase) wrAddr_r <= haddr;
      if (addrPhase && !hwrite) rdData_r <= rdVal;
    end
  end

  // Pin synchroniser and edge history
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pinS1_r <= 1'b1;
      pinS2_r <= 1'b1;
      pinPrev_r <= 1'b1;
    end else begin
      pinS1_r <= power_down_n_pin;
      pinS2_r <= pinS1_r;
      pinPrev_r <= pinS2_r;
    end
  end

  // Prescaler
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) preCnt_r <= '0;
    else preCnt_r <= tick ? '0 : preCnt_r + 32'h1;
  end

  // Control state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      balSel_r <= cbt_pkg::SEL_RST;
      pdtVal_r <= cbt_pkg::ONT_ZERO;
      cntRun_r <= 1'b0;
      cntStep_r <= cbt_pkg::ONT_ZERO;
      cntSub_r <= '0;
      pdRun_r <= 1'b0;
      pdStep_r <= cbt_pkg::ONT_ZERO;
      pdSub_r <= '0;
      pwr_r <= cbt_pkg::PWR_ON;
    end else begin
      balSel_r <= selNxt;
      if (wrPdt) pdtVal_r <= wdOnt;
      cntRun_r <= cntRunNxt;
      cntStep_r <= cntStepNxt;
      cntSub_r <= cntSubNxt;
      pdRun_r <= pdRunNxt;
      pdStep_r <= pdStepNxt;
      pdSub_r <= pdSubNxt;
      pwr_r <= pwrNxt;
    end
  end

  // Outputs
  assign balance_gate_out = balSel_r;
  assign powered_down = pwr_r == cbt_pkg::PWR_OFF;
  assign hreadyout = 1'b1;
  assign hresp = cbt_pkg::HRESP_OKAY;
  assign hrdata = rdData_r;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_sel_clear_off: assert property (
    wrSel && wdSel == SEL_ZERO |=> balance_gate_out == SEL_ZERO)
    else $error("Cleared select left a gate on");

  a_pin_fall_off: assert property (
    goNow |=> balance_gate_out == SEL_ZERO && powered_down)
    else $error("Power-down edge did not turn gates off");

  a_ontime_reset: assert property (
    $past(sys_rst) |-> onTime_r[0] == '0 && onTime_r[5] == '0)
    else $error("On-time register not zero after reset");

  a_expire_clears: assert property (
    |expHit && !wrPend_r |=>
      (balSel_r & $past(expHit)) == SEL_ZERO && $stable(onTime_r[0]))
    else $error("Expired output not cleared or on-time lost");

  a_idle_wr_keep: assert property (
    |wrOnt && !activeHit && !tick && cntRun_r && !goDown &&
      (|(balSel_r & timedVec)) |=> $stable(cntStep_r) && $stable(cntSub_r))
    else $error("Inactive on-time write moved the counter");

  a_active_restart: assert property (
    activeHit && cntRun_r && (|(selNxt & timedVec)) |=>
      cntRun_r && cntStep_r == '0 && cntSub_r == '0)
    else $error("Active on-time write did not restart counter");

  a_sel_starts_cnt: assert property (
    !cntRun_r && wrSel && |(wdSel & timedVec) && isOn && !goDown |=>
      cntRun_r ##1 (cntRun_r || !(|(balSel_r & timedVec))))
    else $error("Select write did not start the counter");

  a_all_done_zero: assert property (
    cntRun_r && !(|(selNxt & timedVec)) |=>
      !cntRun_r && cntStep_r == '0)
    else $error("Counter not cleared after last expiry");

  c_expire: cover property (|expHit);
  c_join_run: cover property (cntRun_r && wrSel && |(wdSel & timedVec));
  c_restart: cover property (activeHit && cntRun_r);
  c_delay_down: cover property (goDelay);

endmodule

// ===== cbt_gate_model.sv
// External balancing transistor gates behind the six balance outputs.
// Assumes the gates are driven only by the block's balance outputs.
`timescale 1ns/1ps
module cbt_gate_model (
  // Gate drive
  input wire logic [5:0] gateIn,
  // Transistor state
  output logic [5:0] fetOn
);
  assign fetOn = gateIn;
endmodule

// ===== cbt_pkg.sv
// Constants and types for the cell balance timer control block.
// Assumes a 100 MHz mclk and an AHB-Lite register bus with 32-bit data.
package cbt_pkg;

  // Channel and field layout
  localparam int unsigned NCH = 6;
  localparam int unsigned SEL_LSB = 2;
  localparam int unsigned ONT_LSB = 3;
  localparam int unsigned ONT_W = 5;
  localparam int unsigned SUB_W = 4;
  localparam logic [SUB_W-1:0] SUB_LAST = 4'hF;
  localparam logic [ONT_W-1:0] ONT_ZERO = 5'h00;
  localparam logic [NCH-1:0] SEL_RST = 6'h00;

  // Register byte offsets
  localparam logic [7:0] OFF_SEL = 8'h00;
  localparam logic [7:0] OFF_ONT1 = 8'h04;
  localparam logic [7:0] OFF_ONT6 = 8'h18;
  localparam logic [7:0] OFF_PDT = 8'h1C;
  localparam logic [7:0] OFF_STAT = 8'h20;

  // Register indices after decode
  localparam logic [3:0] IDX_SEL = 4'h0;
  localparam logic [3:0] IDX_ONT1 = 4'h1;
  localparam logic [3:0] IDX_PDT = 4'h7;
  localparam logic [3:0] IDX_STAT = 4'h8;
  localparam logic [3:0] IDX_NONE = 4'hF;

  // Status register fields
  localparam int unsigned ST_STEP_LSB = 0;
  localparam int unsigned ST_RUN_BIT = 8;
  localparam int unsigned ST_PDRUN_BIT = 9;
  localparam int unsigned ST_DOWN_BIT = 10;
  localparam int unsigned ST_PIN_BIT = 11;

  // Timing: one compare tick is a sixteenth of the 72 s step
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned TICK_MS = 4500;
  localparam int unsigned TICK_CYCLES = TICK_MS * CLK_KHZ;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {PWR_ON, PWR_OFF} cbt_pwr_t;

endpackage

// ===== cell_balance_timer_control_tb_top.sv
// Self-checking bench for the cell balance timer block.
// Assumes a zero-wait-state slave and a short compare tick.
`timescale 1ns/1ps
module cell_balance_timer_control_tb_top;
  localparam int TK = 20;
  localparam logic [7:0] ST = cbt_pkg::OFF_STAT;
  localparam logic [7:0] SEL = cbt_pkg::OFF_SEL;
  logic mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, pinN = 1, rdPh = 0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, pwrDown;
  logic [5:0] gates, fetOn, mask;
  logic [31:0] expQ[$];
  int err_count = 0, samples_checked = 0, cyc = 0, seed = 93, t0 = 0;

  cbt_balance_timer #(.TICK_CYCLES(TK), .ADDR_W(8)) dut (.mclk(mclk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .power_down_n_pin(pinN), .balance_gate_out(gates),
    .powered_down(pwrDown));
  cbt_gate_model fets (.gateIn(gates), .fetOn(fetOn));

  always #5 mclk = ~mclk;

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp32(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("read %h not %h", got, exp));
  endtask
  task automatic cmpGate(input logic [5:0] exp);
    samples_checked++;
    if (fetOn !== exp) fail($sformatf("gates %b not %b", fetOn, exp));
  endtask
  task automatic cmpTime(input int got, lo, hi);
    samples_checked++;
    if (got < lo || got > hi) fail($sformatf("delay %0d", got));
  endtask

  // Bus cycles
  task automatic waitRdy();
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    haddr <= a;
    hwrite <= w;
    htrans <= cbt_pkg::HTRANS_NONSEQ;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  function automatic logic [7:0] ontA(input int i);
    return cbt_pkg::OFF_ONT1 + 8'(4 * (i - 1));
  endfunction
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic waitGates(input logic [5:0] e, input int lo, hi);
    while (fetOn !== e && cyc - t0 < hi + 20) begin
      settle(1);
    end
    cmpTime(cyc - t0, lo, hi);
    cmpGate(e);
  endtask

  // Read data monitor
  always @(posedge mclk) begin
    if (rdPh && hreadyout === 1'b1) begin
      cmp32(hrdata, expQ.pop_front());
      cmp32({31'h0, hresp}, {31'h0, cbt_pkg::HRESP_OKAY});
    end
    if (hreadyout === 1'b1) begin
      rdPh <= htrans == cbt_pkg::HTRANS_NONSEQ && !hwrite;
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail("timeout");
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    hsel <= 1'b1;
    settle(2);
    rd(SEL, 32'h0);
    for (int i = 1; i <= 6; i++) begin
      rd(ontA(i), 32'h0);
    end
    rd(cbt_pkg::OFF_PDT, 32'h0);
    rd(ST, 32'h800);
    wr(8'h40, 32'hFF);
    rd(8'h40, 32'h0);
    // Untimed random selections
    for (int k = 0; k < 4; k++) begin
      mask = 6'($random(seed)) | 6'h01;
      wr(SEL, {24'h0, mask, 2'b00});
      settle(1);
      cmpGate(mask);
      settle(340);
      cmpGate(mask);
      rd(SEL, {24'h0, mask, 2'b00});
    end
    // Arm, activate, join a running count
    wr(ontA(1), 32'h08);
    wr(ontA(2), 32'h08);
    wr(SEL, 32'h0);
    settle(1);
    cmpGate(6'h00);
    rd(ST, 32'h800);
    wr(SEL, 32'h0C);
    t0 = cyc;
    settle(150);
    cmpGate(6'h03);
    wr(ontA(3), 32'h08);
    wr(SEL, 32'h1C);
    settle(1);
    cmpGate(6'h07);
    waitGates(6'h00, 290, 340);
    rd(SEL, 32'h0);
    rd(ontA(3), 32'h08);
    rd(ST, 32'h800);
    // Writes to inactive and active on-time registers
    wr(ontA(3), 32'h0);
    wr(SEL, 32'h04);
    t0 = cyc;
    settle(200);
    wr(ontA(2), 32'h10);
    waitGates(6'h00, 290, 340);
    wr(SEL, 32'h04);
    t0 = cyc;
    settle(200);
    wr(ontA(1), 32'h08);
    waitGates(6'h00, 490, 545);
    wr(ontA(2), 32'h0);
    wr(SEL, 32'h04);
    settle(50);
    wr(SEL, 32'h0);
    settle(1);
    cmpGate(6'h00);
    wr(SEL, 32'h0C);
    settle(50);
    wr(ontA(1), 32'h0);
    settle(1);
    cmpGate(6'h02);
    // Power-down pin, no delay then delayed
    wr(SEL, 32'hFC);
    @(posedge mclk);
    pinN <= 1'b0;
    settle(6);
    cmpGate(6'h00);
    cmp32({31'h0, pwrDown}, 32'h1);
    rd(ST, 32'h400);
    pinN <= 1'b1;
    settle(8);
    rd(ST, 32'h800);
    wr(cbt_pkg::OFF_PDT, 32'h08);
    wr(SEL, 32'hFC);
    @(posedge mclk);
    pinN <= 1'b0;
    t0 = cyc;
    settle(100);
    cmpGate(6'h3F);
    rd(ST, 32'h200);
    while (pwrDown !== 1'b1 && cyc - t0 < 400) begin
      settle(1);
    end
    cmpTime(cyc - t0, 290, 345);
    cmpGate(6'h00);
    stop_test();
  end
endmodule
